// ### tb/sspf_board.sv
// Board model: pulled-up pad wires and downstream reset sensing
`timescale 1ns/1ns
module sspf_board (
  input  wire sspf_pkg::sspf_pad_t pad,      // Device pad drive
  input  wire logic [6:0]          ext_oe,   // Board drives pin
  input  wire logic [6:0]          ext_val,  // Board drive level
  output logic [6:0]               pad_in,   // Wire levels
  output logic [4:0]               port_rst  // Port held in reset
);
  import sspf_pkg::*;
  assign pad_in = (~pad.oe_n & pad.out) | (pad.oe_n & ~ext_oe)
                | (pad.oe_n & ext_oe & ext_val);
  assign port_rst = ~{pad_in[6], pad_in[1], pad_in[5], pad_in[0], pad_in[4]};
endmodule

// ### tb/sspf_props.sv
// Checker: port assertions for the strap and pin function block
`timescale 1ns/1ns
module sspf_props import sspf_pkg::*; (
  input wire logic                    sys_clk,              // Clock
  input wire logic                    rstn,                 // Reset
  input wire logic                    fundamental_reset_in, // Pin
  input wire sspf_pkg::sspf_pin_ctl_t pin_ctl,              // Select
  input wire logic [6:0]              pad_in,               // Pads
  input wire sspf_pkg::sspf_pad_t     pad,                  // Drive
  input wire logic [4:0]              down_port_reset_req,  // Requests
  input wire logic                    expander_irq0,        // Irq
  input wire logic                    link_reset_start,     // Pulse
  input wire logic                    logic_reset_n,        // Reset out
  input wire sspf_pkg::sspf_mode_t    switch_mode           // Mode
);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence irq_pin_low;
    pin_ctl.alt_sel[2] && !pad_in[2];
  endsequence
  sequence perst_held;
    !fundamental_reset_in [*5];
  endsequence
  chk_port1_low: assert property (
    pin_ctl.alt_sel[4] && down_port_reset_req[0] |=> !pad.out[4] &&
    !pad.oe_n[4]) else $error("port 1 reset pin not driven low");
  chk_pin2_released: assert property (
    pin_ctl.alt_sel[2] |=> pad.oe_n[2]) else $error("pin 2 driven");
  chk_gpio_drive: assert property (
    fundamental_reset_in && logic_reset_n |=>
    (((~pad.oe_n ^ $past(pin_ctl.gpio_oe)) | ((pad.out ^
    $past(pin_ctl.gpio_out)) & $past(pin_ctl.gpio_oe))) &
    ~$past(pin_ctl.alt_sel)) == 7'h00) else $error("gpio drive wrong");
  chk_irq_follow: assert property (
    irq_pin_low [*5] |-> expander_irq0) else $error("irq not seen");
  chk_pulse_single: assert property (
    link_reset_start |=> !link_reset_start) else $error("long pulse");
  chk_pulse_cause: assert property (
    $fell(fundamental_reset_in) |-> ##[2:4] link_reset_start)
    else $error("no link reset pulse");
  chk_logic_reset: assert property (
    perst_held |-> !logic_reset_n) else $error("logic not in reset");
  chk_mode_held: assert property (
    logic_reset_n [*4] |-> $stable(switch_mode))
    else $error("mode changed after release");
endmodule
bind sspf_top sspf_props u_props (.sys_clk, .rstn, .fundamental_reset_in,
  .pin_ctl, .pad_in, .pad, .down_port_reset_req, .expander_irq0,
  .link_reset_start, .logic_reset_n, .switch_mode);

// ### tb/tb.sv
// Testbench: straps, pin functions and slot clock bits
`timescale 1ns/1ns
module tb;
  import sspf_pkg::*;
  logic          sys_clk, rstn, fundamental_reset_in, general_event;
  logic          downstream_common_clock_strap, upstream_common_clock_strap;
  logic [2:0]    switch_mode_strap;
  logic [4:0]    down_port_reset_req, link_status_sclk, port_rst;
  logic [6:0]    pad_in, gpio_in, ext_oe, ext_val;
  logic          expander_irq0, upstream_link_status_sclk, link_reset_start;
  logic          logic_reset_n, eeprom_init_req, mode_reserved;
  sspf_pin_ctl_t pin_ctl;
  sspf_pad_t     pad;
  sspf_sclk_wr_t sclk_wr;
  sspf_mode_t    switch_mode;
  int            err_count, compares;
  sspf_top dut (.sys_clk, .rstn, .fundamental_reset_in, .switch_mode_strap,
    .downstream_common_clock_strap, .upstream_common_clock_strap, .pin_ctl,
    .pad_in, .pad, .gpio_in, .down_port_reset_req, .general_event,
    .expander_irq0, .sclk_wr, .link_status_sclk, .upstream_link_status_sclk,
    .link_reset_start, .logic_reset_n, .switch_mode, .eeprom_init_req,
    .mode_reserved);
  sspf_board brd (.pad, .ext_oe, .ext_val, .pad_in, .port_rst);
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic freset(input logic [2:0] md, input logic ds, input logic us);
    int n;
    n = 0;
    switch_mode_strap = md;
    downstream_common_clock_strap = ds;
    upstream_common_clock_strap = us;
    fundamental_reset_in = 1'b0;
    repeat (6) begin
      cyc(1);
      n += int'(link_reset_start);
    end
    chk(8'(logic_reset_n), 8'h00);
    chk(8'(port_rst), 8'h1f);
    chk(8'(n), 8'h01);
    fundamental_reset_in = 1'b1;
    cyc(6);
  endtask
  task automatic t_strap;
    sspf_mode_t em;
    for (int m = 0; m < 8; m++) begin
      em = m == 0 ? SSPF_SEL_NORMAL
         : m == 1 ? SSPF_SEL_NORMAL_EE : SSPF_SEL_RESERVED;
      freset(3'(m), m[0], m[1]);
      chk(8'(switch_mode), 8'(em));
      chk(8'(mode_reserved), 8'(m > 1));
      chk(8'(eeprom_init_req), 8'(m == 1));
      chk(8'(link_status_sclk), 8'({5{m[0]}}));
      chk(8'(upstream_link_status_sclk), 8'(m[1]));
      switch_mode_strap = ~switch_mode_strap;
      downstream_common_clock_strap = ~m[0];
      cyc(6);
      chk(8'(switch_mode), 8'(em));
      chk(8'(link_status_sclk), 8'({5{m[0]}}));
    end
    $display("strap test done");
  endtask
  task automatic t_pins;
    for (int p = 0; p < 5; p++) begin
      down_port_reset_req = 5'(1 << p);
      cyc(2);
      chk(8'(port_rst), 8'(1 << p));
    end
    down_port_reset_req = 5'h00;
    general_event = 1'b1;
    cyc(2);
    chk(8'(pad_in[3]), 8'h00);
    general_event = 1'b0;
    ext_oe = 7'h04;
    cyc(5);
    chk(8'(pad_in[3]), 8'h01);
    chk(8'(expander_irq0), 8'h01);
    ext_oe = 7'h00;
    cyc(5);
    chk(8'(expander_irq0), 8'h00);
    $display("pin function test done");
  endtask
  task automatic t_gpio;
    pin_ctl = '{7'h00, 7'h55, 7'h14};
    ext_oe = 7'h2a;
    ext_val = 7'h08;
    down_port_reset_req = 5'h1f;
    general_event = 1'b1;
    cyc(5);
    chk(8'(gpio_in), 8'h1c);
    pin_ctl = '{7'h7f, 7'h00, 7'h00};
    ext_oe = 7'h00;
    down_port_reset_req = 5'h00;
    general_event = 1'b0;
    cyc(2);
    $display("gpio test done");
  endtask
  task automatic t_sclk;
    sclk_wr = '{1'b1, 1'b0, 5'h1f, 5'h0a};
    cyc(1);
    sclk_wr = '{1'b1, 1'b1, 5'h04, 5'h04};
    cyc(1);
    sclk_wr = '0;
    cyc(1);
    chk(8'(link_status_sclk), 8'h0e);
    chk(8'(upstream_link_status_sclk), 8'h01);
    fundamental_reset_in = 1'b0;
    cyc(6);
    sclk_wr = '{1'b1, 1'b1, 5'h1f, 5'h1f};
    cyc(1);
    sclk_wr = '0;
    cyc(1);
    chk(8'(link_status_sclk), 8'h00);
    chk(8'(upstream_link_status_sclk), 8'h00);
    fundamental_reset_in = 1'b1;
    cyc(6);
    $display("slot clock test done");
  endtask
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    rstn = 1'b0;
    fundamental_reset_in = 1'b1;
    switch_mode_strap = 3'h0;
    downstream_common_clock_strap = 1'b1;
    upstream_common_clock_strap = 1'b1;
    pin_ctl = '{7'h7f, 7'h00, 7'h00};
    ext_oe = 7'h00;
    ext_val = 7'h00;
    down_port_reset_req = 5'h00;
    general_event = 1'b0;
    sclk_wr = '0;
    err_count = 0;
    compares = 0;
    cyc(10);
    rstn = 1'b1;
    cyc(2);
    chk(8'(expander_irq0), 8'h00);
    chk(8'(gpio_in), 8'h7f);
    cyc(4);
    t_strap;
    t_pins;
    t_gpio;
    t_sclk;
    print_verdict;
  end
  // Whole run needs about 210 cycles
  initial begin
    #20000;
    err_count++;
    print_verdict;
  end
endmodule

// ### verilog/sspf_pkg.sv
// Package: constants and types for the switch strap and pin function block
package sspf_pkg;

  localparam int SSPF_NUM_GPIO   = 7;
  localparam int SSPF_NUM_DSPORT = 5;

  // Pin vector index for each physical pin: 0,1,2,7,8,9,10
  localparam int SSPF_IDX_PIN0  = 0;
  localparam int SSPF_IDX_PIN1  = 1;
  localparam int SSPF_IDX_PIN2  = 2;
  localparam int SSPF_IDX_PIN7  = 3;
  localparam int SSPF_IDX_PIN8  = 4;
  localparam int SSPF_IDX_PIN9  = 5;
  localparam int SSPF_IDX_PIN10 = 6;

  // Switch mode strap encodings
  localparam logic [2:0] SSPF_MODE_NORMAL    = 3'h0;
  localparam logic [2:0] SSPF_MODE_NORMAL_EE = 3'h1;

  // Values after reset; pad synchronisers start at the pulled-up level
  localparam logic [6:0] SSPF_RST_GPIO    = 7'h7f;
  localparam logic [2:0] SSPF_RST_STRAP   = 3'h0;
  localparam logic       SSPF_RST_BIT     = 1'b0;
  localparam logic [4:0] SSPF_RST_DSCLK   = 5'h00;
  localparam logic [4:0] SSPF_DSPORT_HIGH = 5'h1f;

  typedef enum logic [1:0] {
    SSPF_SEL_NORMAL,
    SSPF_SEL_NORMAL_EE,
    SSPF_SEL_RESERVED
  } sspf_mode_t;

  // Per-pin control from core logic
  typedef struct packed {
    logic [6:0] alt_sel;   // 1 = alternate function
    logic [6:0] gpio_oe;   // 1 = drive pin in plain GPIO mode
    logic [6:0] gpio_out;  // GPIO output level
  } sspf_pin_ctl_t;

  // Pad signals of the seven pins
  typedef struct packed {
    logic [6:0] out;
    logic [6:0] oe_n;      // Low while the block drives the pin
  } sspf_pad_t;

  // Slot clock configuration write from software
  typedef struct packed {
    logic       us_we;
    logic       us_val;
    logic [4:0] ds_we;
    logic [4:0] ds_val;
  } sspf_sclk_wr_t;

endpackage

// ### verilog/sspf_top.sv
// Module: pin function mux, strap capture and reset fan-out
//------------------------------------------------------------
//------------------------------------------------------------
`timescale 1ns/1ns
module sspf_top (
  input  wire logic                   sys_clk,        // 100 MHz clock
  input  wire logic                   rstn,           // Core reset, low
  input  wire logic                   fundamental_reset_in, // Pin, low
  input  wire logic [2:0]             switch_mode_strap,     // Strap pins
  input  wire logic                   downstream_common_clock_strap, // Pin
  input  wire logic                   upstream_common_clock_strap,   // Pin
  input  wire sspf_pkg::sspf_pin_ctl_t pin_ctl,       // Per-pin select
  input  wire logic [6:0]             pad_in,         // Pad input levels
  output sspf_pkg::sspf_pad_t         pad,            // Pad drive
  output logic [6:0]                  gpio_in,        // Synced pin levels
  input  wire logic [4:0]             down_port_reset_req, // Core, high
  input  wire logic                   general_event,  // Core event, high
  output logic                        expander_irq0,  // Interrupt, high
  input  wire sspf_pkg::sspf_sclk_wr_t sclk_wr,       // Software writes
  output logic [4:0]                  link_status_sclk, // Downstream bits
  output logic                        upstream_link_status_sclk, // Up bit
  output logic                        link_reset_start, // Pulse
  output logic                        logic_reset_n,  // Internal reset
  output sspf_pkg::sspf_mode_t        switch_mode,    // Decoded mode
  output logic                        eeprom_init_req, // Mode 1 level
  output logic                        mode_reserved   // Reserved code
);
  import sspf_pkg::*;

  //------------------------------------------------------------
  // Input synchronisers
  //------------------------------------------------------------
  logic [6:0] pad_s1_r;
  logic [6:0] pad_s2_r;
  logic       perst_s1_r;
  logic       perst_s2_r;
  logic       perst_d_r;
  logic [4:0] strap_s1_r;
  logic [4:0] strap_s2_r;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      // Pads reset to their pulled-up idle level: no false interrupt
      pad_s1_r   <= SSPF_RST_GPIO;
      pad_s2_r   <= SSPF_RST_GPIO;
      strap_s1_r <= SSPF_RST_DSCLK;
      strap_s2_r <= SSPF_RST_DSCLK;
    end else begin
      pad_s1_r   <= pad_in;
      pad_s2_r   <= pad_s1_r;
      strap_s1_r <= {switch_mode_strap, downstream_common_clock_strap,
                     upstream_common_clock_strap};
      strap_s2_r <= strap_s1_r;
    end
  end

  // Reset pin sampled low-active; held asserted while rstn is low
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      perst_s1_r <= SSPF_RST_BIT;
      perst_s2_r <= SSPF_RST_BIT;
      perst_d_r  <= SSPF_RST_BIT;
    end else begin
      perst_s1_r <= fundamental_reset_in;
      perst_s2_r <= perst_s1_r;
      perst_d_r  <= perst_s2_r;
    end
  end

  // Low level is the asserted fundamental reset
  logic perst_active;
  logic perst_release;
  assign perst_active  = ~perst_s2_r;
  assign perst_release = perst_s2_r & ~perst_d_r;

  //------------------------------------------------------------
  // Fundamental reset effects
  //------------------------------------------------------------
  // Internal reset and link reset kick
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      logic_reset_n    <= SSPF_RST_BIT;
      link_reset_start <= SSPF_RST_BIT;
    end else begin
      logic_reset_n    <= ~perst_active;
      // Fall seen past the second flop; the first never feeds logic
      link_reset_start <= perst_d_r & ~perst_s2_r;
    end
  end

  //------------------------------------------------------------
  // Strap capture
  //------------------------------------------------------------
  logic [2:0] mode_r;

  // Later strap changes are ignored until next reset
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mode_r <= SSPF_RST_STRAP;
    end else if (perst_active) begin
      mode_r <= SSPF_RST_STRAP;
    end else if (perst_release) begin
      mode_r <= strap_s2_r[4:2];
    end
  end

  function automatic sspf_mode_t decode_mode(input logic [2:0] code);
    case (code)
      SSPF_MODE_NORMAL:    decode_mode = SSPF_SEL_NORMAL;
      SSPF_MODE_NORMAL_EE: decode_mode = SSPF_SEL_NORMAL_EE;
      default:             decode_mode = SSPF_SEL_RESERVED;
    endcase
  endfunction

  assign switch_mode     = decode_mode(mode_r);
  assign eeprom_init_req = (switch_mode == SSPF_SEL_NORMAL_EE);
  assign mode_reserved   = (switch_mode == SSPF_SEL_RESERVED);

  //------------------------------------------------------------
  // Slot clock configuration bits
  //------------------------------------------------------------
  // Seed downstream bits from strap, then per-port writes
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      link_status_sclk <= SSPF_RST_DSCLK;
    end else if (perst_active) begin
      link_status_sclk <= SSPF_RST_DSCLK;
    end else if (perst_release) begin
      link_status_sclk <= strap_s2_r[1] ? SSPF_DSPORT_HIGH : SSPF_RST_DSCLK;
    end else begin
      for (int i = 0; i < SSPF_NUM_DSPORT; i++) begin
        if (sclk_wr.ds_we[i]) begin
          link_status_sclk[i] <= sclk_wr.ds_val[i];
        end
      end
    end
  end

  // Seed upstream bit from strap, then software write
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      upstream_link_status_sclk <= SSPF_RST_BIT;
    end else if (perst_active) begin
      upstream_link_status_sclk <= SSPF_RST_BIT;
    end else if (perst_release) begin
      upstream_link_status_sclk <= strap_s2_r[0];
    end else if (sclk_wr.us_we) begin
      upstream_link_status_sclk <= sclk_wr.us_val;
    end
  end

  //------------------------------------------------------------
  // Pin function mux
  //------------------------------------------------------------
  logic [6:0] alt_out;
  logic [6:0] alt_drv;
  logic [6:0] out_nxt;
  logic [6:0] oe_nxt;

  // Port resets on pins 8,0,9,1,10, held while in reset
  // Event output on pin 7, driven low when asserted
  always_comb begin
    logic [4:0] rst_req;
    rst_req = down_port_reset_req | {5{perst_active}};
    alt_out = 7'h7f;
    alt_drv = 7'h7f;
    alt_out[SSPF_IDX_PIN8]  = ~rst_req[0];
    alt_out[SSPF_IDX_PIN0]  = ~rst_req[1];
    alt_out[SSPF_IDX_PIN9]  = ~rst_req[2];
    alt_out[SSPF_IDX_PIN1]  = ~rst_req[3];
    alt_out[SSPF_IDX_PIN10] = ~rst_req[4];
    alt_out[SSPF_IDX_PIN7]  = ~general_event;
    // Pin 2 alternate is an input only
    alt_drv[SSPF_IDX_PIN2]  = 1'b0;
  end

  // Per-pin choice between GPIO and alternate function
  always_comb begin
    for (int i = 0; i < SSPF_NUM_GPIO; i++) begin
      out_nxt[i] = pin_ctl.alt_sel[i] ? alt_out[i] : pin_ctl.gpio_out[i];
      oe_nxt[i]  = pin_ctl.alt_sel[i] ? alt_drv[i] : pin_ctl.gpio_oe[i];
    end
  end

  // Registered pad drive; enable is low-active at the pad
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pad.out  <= 7'h7f;
      pad.oe_n <= 7'h7f;
    end else begin
      pad.out  <= out_nxt;
      pad.oe_n <= ~oe_nxt;
    end
  end

  assign gpio_in = pad_s2_r;

  // Limitation: a low pulse shorter than one clock may be missed
  // Expander interrupt is low-active on the pin
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      expander_irq0 <= SSPF_RST_BIT;
    end else begin
      expander_irq0 <= pin_ctl.alt_sel[SSPF_IDX_PIN2] &
                       ~pad_s2_r[SSPF_IDX_PIN2];
    end
  end

endmodule
